/* File: rtl/ipc_pkg.sv */
package ipc_pkg;

    ////////////////////////////////////////////////////////////////////////
    // sizes
    localparam int NSRC = 16;            // sources held in this block
    localparam int EXT_N = 5;            // external edge pins
    localparam int PRIO_W = 3;           // per-source priority width
    localparam int PRIO_PER_WORD = 4;    // priority nibbles per word
    localparam int PRIO_WORDS = 4;       // priority registers
    localparam int EVT_N = 2;            // event status bits

    ////////////////////////////////////////////////////////////////////////
    // register byte offsets on the apb
    localparam logic [7:0] OFS_CPU_STATUS = 8'h00; // cpu_status_word
    localparam logic [7:0] OFS_CORE_CTRL = 8'h04;  // core_control_word
    localparam logic [7:0] OFS_CTRL_ONE = 8'h08;   // irq_control_one
    localparam logic [7:0] OFS_CTRL_TWO = 8'h0c;   // irq_control_two
    localparam logic [7:0] OFS_FLAG = 8'h10;       // request_flag_reg_zero
    localparam logic [7:0] OFS_ENABLE = 8'h14;     // source_enable_reg_zero
    localparam logic [7:0] OFS_PRIO0 = 8'h18;      // priority words 0..3
    localparam logic [7:0] OFS_PENDING = 8'h28;    // pending_vector_reg
    localparam logic [7:0] OFS_EVT_STAT = 8'h2c;   // event status, w1c
    localparam logic [7:0] OFS_EVT_MASK = 8'h30;   // event mask

    ////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int LVL_LSB = 5;          // cpu level bits 7:5
    localparam int LVL_TOP_BIT = 3;      // fourth level bit
    localparam int NEST_BIT = 15;        // nesting disable
    localparam int DIV0_BIT = 6;         // divide by zero cause
    localparam int TRAP_LSB = 1;         // trap flags bits 5:1
    localparam int ALT_BIT = 15;         // alternate table select
    localparam int HOLD_BIT = 14;        // irq hold active status
    localparam int EVT_PEND_BIT = 0;     // new pending event
    localparam int EVT_TRAP_BIT = 1;     // trap event

    ////////////////////////////////////////////////////////////////////////
    // values
    localparam logic [6:0] VEC_BASE = 7'h08;   // vector of source 0
    localparam logic [15:0] RESET_WORD = 16'h0000;

    ////////////////////////////////////////////////////////////////////////
    // carriers
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } ipc_apb_req_t;

    typedef struct packed {
        logic div0;   // cause qualifier for math trap
        logic dma;
        logic math;
        logic addr;
        logic stk;
        logic osc;
    } ipc_trap_t;

endpackage : ipc_pkg

/* File: rtl/ipc_top.sv */
// Our own choices: the placing of the registers and register access over APB.
`timescale 1ns/100ps
// Operation
// RULE1: per-source flag, hardware sets, software clears
// RULE2: per-source enable gates each source
// RULE3: three-bit priority per source, eight levels
// RULE4: latch pending vector and new level
// RULE5: flag, enable, priority in vector order
// RULE6: cpu level low bits at 7:5, writable
// RULE7: fourth level bit read or clear only
// RULE8: level is top bit over low field
// RULE9: nesting disable freezes cpu level field; an irq ack still loads it
// RULE10: nesting disable bit at bit 15
// RULE11: divide by zero cause at bit 6
// RULE12: sticky trap flags bits 5 to 1
// RULE13: bit 15 selects alternate vector table
// RULE14: bit 14 shows irq hold active
// RULE15: bits 4:0 select external edge polarity
// RULE16: unimplemented bits read zero, ignore writes
// RULE17: all implemented bits clear at reset
// RULE18: pending needs flag, enable, priority above level
module ipc_top (
    input wire logic core_clk_i,                 // system clock 10 MHz
    input wire logic reset_n_i,                  // async reset, low
    input wire ipc_pkg::ipc_apb_req_t apb_i,     // apb request group
    output logic pready_o,                       // apb ready
    output logic [31:0] prdata_o,                // apb read data
    output logic pslverr_o,                      // apb error, unmapped
    input wire logic [ipc_pkg::NSRC-1:0] src_req_i, // peripheral pulses
    input wire logic [ipc_pkg::EXT_N-1:0] ext_pin_i, // external pins
    input wire ipc_pkg::ipc_trap_t trap_i,       // trap event pulses
    input wire logic irq_hold_i,                 // hold instruction active
    input wire logic irq_ack_i,                  // cpu takes pending irq
    output logic irq_req_o,                      // pending irq to cpu
    output logic [6:0] irq_vector_o,             // pending vector number
    output logic [3:0] irq_level_o,              // pending new level
    output logic alt_table_o,                    // use alternate table
    output logic [ipc_pkg::EXT_N-1:0] ext_edge_o, // selected edge seen
    output logic irq_o                           // event interrupt
);

    ////////////////////////////////////////////////////////////////////////
    // reset release through two flops
    logic rst_meta;   // first stage, read only by rst_n
    logic rst_n;      // design reset copy

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state
    logic pready;                               // access completes
    logic [31:0] prdata;                        // read data
    logic pslverr;                              // unmapped access
    logic [2:0] cpu_level_low;                  // level bits 7:5
    logic cpu_level_top;                        // fourth level bit
    logic nesting_disable;                      // blocks software writes to level bits 7:5
    logic divide_zero_cause;                    // math trap from div0
    logic [4:0] trap_flags;                     // dma,math,addr,stk,osc
    logic alternate_table_select;               // table select
    logic irq_hold_active;                      // sampled hold status
    logic [ipc_pkg::EXT_N-1:0] edge_polarity;   // 1 negative edge
    logic [ipc_pkg::EXT_N-1:0] ext_prev;        // last pin sample
    logic ext_primed;                           // pins sampled since reset
    logic [ipc_pkg::EXT_N-1:0] ext_edge;        // edge seen, registered
    logic [ipc_pkg::NSRC-1:0] request_flag;     // per-source flags
    logic [ipc_pkg::NSRC-1:0] source_enable;    // per-source enables
    logic [2:0] source_priority [ipc_pkg::NSRC]; // per-source level
    logic [6:0] pending_vector_number;          // latched vector
    logic [3:0] pending_new_level;              // latched level
    logic pending_valid;                        // request to cpu
    logic [ipc_pkg::EVT_N-1:0] evt_status;      // sticky events
    logic [ipc_pkg::EVT_N-1:0] evt_mask;        // event mask
    logic irq;                                  // event interrupt

    // next values
    logic next_pready;
    logic [31:0] next_prdata;
    logic next_pslverr;
    logic [2:0] next_cpu_level_low;
    logic next_cpu_level_top;
    logic next_nesting_disable;
    logic next_divide_zero_cause;
    logic [4:0] next_trap_flags;
    logic next_alternate_table_select;
    logic [ipc_pkg::EXT_N-1:0] next_edge_polarity;
    logic [ipc_pkg::EXT_N-1:0] next_ext_edge;
    logic [ipc_pkg::NSRC-1:0] next_request_flag;
    logic [ipc_pkg::NSRC-1:0] next_source_enable;
    logic [2:0] next_source_priority [ipc_pkg::NSRC];
    logic [6:0] next_pending_vector_number;
    logic [3:0] next_pending_new_level;
    logic next_pending_valid;
    logic [ipc_pkg::EVT_N-1:0] next_evt_status;
    logic [ipc_pkg::EVT_N-1:0] next_evt_mask;
    logic next_irq;

    // decoded strobes and helpers
    logic wr_en;                                // write takes effect now
    logic [4:0] trap_vec;                       // trap pulses as a word
    logic trap_any;                             // any trap this cycle
    logic best_found;                           // a source qualifies
    logic [3:0] best_idx;                       // winning source
    logic [2:0] best_prio;                      // its priority

    assign wr_en = apb_i.psel & apb_i.penable & pready & apb_i.pwrite;
    assign trap_vec = {trap_i.dma, trap_i.math, trap_i.addr,
                       trap_i.stk, trap_i.osc};
    assign trap_any = |trap_vec;

    ////////////////////////////////////////////////////////////////////////
    // apb slave: one wait cycle, data and ready from flops
    always_comb begin
        next_pready = apb_i.psel & apb_i.penable & ~pready;
        next_prdata = 32'h0000_0000;
        next_pslverr = 1'b0;
        unique case (apb_i.paddr)
            ipc_pkg::OFS_CPU_STATUS: begin
                next_prdata = {24'h00_0000, cpu_level_low, 5'h00}; // RULE6
            end
            ipc_pkg::OFS_CORE_CTRL: begin
                next_prdata = {28'h000_0000, cpu_level_top, 3'h0}; // RULE7
            end
            ipc_pkg::OFS_CTRL_ONE: begin
                next_prdata = {16'h0000, nesting_disable, 8'h00,
                               divide_zero_cause, trap_flags, 1'b0}; // RULE16
            end
            ipc_pkg::OFS_CTRL_TWO: begin
                next_prdata = {16'h0000, alternate_table_select,
                               irq_hold_active, 9'h000,
                               edge_polarity}; // RULE16
            end
            ipc_pkg::OFS_FLAG: begin
                next_prdata = {16'h0000, request_flag};
            end
            ipc_pkg::OFS_ENABLE: begin
                next_prdata = {16'h0000, source_enable};
            end
            ipc_pkg::OFS_PENDING: begin
                next_prdata = {20'h0_0000, pending_new_level, 1'b0,
                               pending_vector_number}; // RULE4
            end
            ipc_pkg::OFS_EVT_STAT: begin
                next_prdata = {30'h0000_0000, evt_status};
            end
            ipc_pkg::OFS_EVT_MASK: begin
                next_prdata = {30'h0000_0000, evt_mask};
            end
            default: begin
                // priority words, or an unmapped address
                next_pslverr = 1'b1;
                for (int w = 0; w < ipc_pkg::PRIO_WORDS; w++) begin
                    if (apb_i.paddr == ipc_pkg::OFS_PRIO0 + 8'(4 * w)) begin
                        next_pslverr = 1'b0;
                        for (int k = 0; k < ipc_pkg::PRIO_PER_WORD; k++) begin
                            next_prdata[4*k +: 3] =
                                source_priority[w*4 + k]; // RULE3 RULE5
                        end
                    end
                end
            end
        endcase
    end

    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready <= next_pready;
            prdata <= next_prdata;
            pslverr <= next_pslverr;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // cpu level, control words and trap flags
    always_comb begin
        next_cpu_level_low = cpu_level_low;
        next_cpu_level_top = cpu_level_top;
        next_nesting_disable = nesting_disable;
        next_divide_zero_cause = divide_zero_cause;
        next_trap_flags = trap_flags;
        next_alternate_table_select = alternate_table_select;
        next_edge_polarity = edge_polarity;
        // software level change, refused while nesting is off
        if (wr_en && apb_i.paddr == ipc_pkg::OFS_CPU_STATUS &&
            !nesting_disable) begin
            next_cpu_level_low = apb_i.pwdata[7:5]; // RULE6 RULE9
        end
        // taking an irq raises the level to its priority
        if (irq_ack_i && pending_valid) begin
            next_cpu_level_low = pending_new_level[2:0];
        end
        // fourth bit: a written zero clears, a one is ignored
        if (wr_en && apb_i.paddr == ipc_pkg::OFS_CORE_CTRL &&
            !apb_i.pwdata[ipc_pkg::LVL_TOP_BIT]) begin
            next_cpu_level_top = 1'b0; // RULE7
        end
        if (trap_any) begin
            next_cpu_level_top = 1'b1; // traps cannot be masked
        end
        if (wr_en && apb_i.paddr == ipc_pkg::OFS_CTRL_ONE) begin
            next_nesting_disable = apb_i.pwdata[ipc_pkg::NEST_BIT]; // RULE10
            next_divide_zero_cause = apb_i.pwdata[ipc_pkg::DIV0_BIT];
            next_trap_flags = apb_i.pwdata[5:1]; // RULE12
        end
        // hardware sets win over a clearing write
        next_trap_flags = next_trap_flags | trap_vec; // RULE12
        if (trap_i.math && trap_i.div0) begin
            next_divide_zero_cause = 1'b1; // RULE11
        end
        if (wr_en && apb_i.paddr == ipc_pkg::OFS_CTRL_TWO) begin
            next_alternate_table_select =
                apb_i.pwdata[ipc_pkg::ALT_BIT]; // RULE13
            next_edge_polarity = apb_i.pwdata[4:0]; // RULE15
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            cpu_level_low <= 3'h0; // RULE17
            cpu_level_top <= 1'b0;
            nesting_disable <= 1'b0;
            divide_zero_cause <= 1'b0;
            trap_flags <= 5'h00;
            alternate_table_select <= 1'b0;
            edge_polarity <= 5'h00;
            irq_hold_active <= 1'b0;
            ext_prev <= 5'h00;
            ext_primed <= 1'b0;
        end else begin
            cpu_level_low <= next_cpu_level_low;
            cpu_level_top <= next_cpu_level_top;
            nesting_disable <= next_nesting_disable;
            divide_zero_cause <= next_divide_zero_cause;
            trap_flags <= next_trap_flags;
            alternate_table_select <= next_alternate_table_select;
            edge_polarity <= next_edge_polarity;
            irq_hold_active <= irq_hold_i; // RULE14
            ext_prev <= ext_pin_i;
            ext_primed <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sources: edges, flags, enables, priorities
    always_comb begin
        // polarity one looks for a fall, zero for a rise
        // no edge before the first real sample: a pin idling high
        // would otherwise look like a rise right after reset
        for (int e = 0; e < ipc_pkg::EXT_N; e++) begin
            next_ext_edge[e] = ext_primed & (edge_polarity[e] ?
                (ext_prev[e] & ~ext_pin_i[e]) :
                (~ext_prev[e] & ext_pin_i[e])); // RULE15
        end
        next_request_flag = request_flag;
        next_source_enable = source_enable;
        next_source_priority = source_priority;
        if (wr_en && apb_i.paddr == ipc_pkg::OFS_FLAG) begin
            next_request_flag = apb_i.pwdata[15:0];
        end
        // set wins: a source firing during a clear stays flagged
        next_request_flag = next_request_flag | src_req_i |
            {15'h0000, next_ext_edge[0]}; // RULE1 RULE5
        if (wr_en && apb_i.paddr == ipc_pkg::OFS_ENABLE) begin
            next_source_enable = apb_i.pwdata[15:0]; // RULE2
        end
        for (int w = 0; w < ipc_pkg::PRIO_WORDS; w++) begin
            if (wr_en && apb_i.paddr == ipc_pkg::OFS_PRIO0 + 8'(4 * w)) begin
                for (int k = 0; k < ipc_pkg::PRIO_PER_WORD; k++) begin
                    next_source_priority[w*4 + k] =
                        apb_i.pwdata[4*k +: 3]; // RULE3 RULE16
                end
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            ext_edge <= 5'h00;
            request_flag <= ipc_pkg::RESET_WORD;
            source_enable <= ipc_pkg::RESET_WORD;
            for (int s = 0; s < ipc_pkg::NSRC; s++) begin
                source_priority[s] <= 3'h0;
            end
        end else begin
            ext_edge <= next_ext_edge;
            request_flag <= next_request_flag;
            source_enable <= next_source_enable;
            source_priority <= next_source_priority;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // arbitration: highest priority wins, ties to lowest natural order
    always_comb begin
        best_found = 1'b0;
        best_idx = 4'h0;
        best_prio = 3'h0;
        for (int s = 0; s < ipc_pkg::NSRC; s++) begin
            // four-bit compare puts every level with top bit set above 7
            if (request_flag[s] && source_enable[s] &&
                {1'b0, source_priority[s]} >
                {cpu_level_top, cpu_level_low} &&
                (!best_found || source_priority[s] > best_prio)) begin
                best_found = 1'b1; // RULE2 RULE8 RULE18
                best_idx = 4'(s);
                best_prio = source_priority[s];
            end
        end
        next_pending_valid = best_found;
        next_pending_vector_number = pending_vector_number;
        next_pending_new_level = pending_new_level;
        // last winner stays readable after the request goes away
        if (best_found) begin
            next_pending_vector_number =
                ipc_pkg::VEC_BASE + {3'h0, best_idx}; // RULE4 RULE5
            next_pending_new_level = {1'b0, best_prio}; // RULE4
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            pending_valid <= 1'b0;
            pending_vector_number <= 7'h00;
            pending_new_level <= 4'h0;
        end else begin
            pending_valid <= next_pending_valid;
            pending_vector_number <= next_pending_vector_number;
            pending_new_level <= next_pending_new_level;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // event status, mask and interrupt line
    always_comb begin
        next_evt_status = evt_status;
        next_evt_mask = evt_mask;
        if (wr_en && apb_i.paddr == ipc_pkg::OFS_EVT_STAT) begin
            next_evt_status = evt_status & ~apb_i.pwdata[1:0];
        end
        if (wr_en && apb_i.paddr == ipc_pkg::OFS_EVT_MASK) begin
            next_evt_mask = apb_i.pwdata[1:0];
        end
        // new events beat a clear in the same cycle
        next_evt_status[ipc_pkg::EVT_PEND_BIT] =
            next_evt_status[ipc_pkg::EVT_PEND_BIT] |
            (best_found & ~pending_valid);
        next_evt_status[ipc_pkg::EVT_TRAP_BIT] =
            next_evt_status[ipc_pkg::EVT_TRAP_BIT] | trap_any;
        next_irq = |(next_evt_status & next_evt_mask);
    end

    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            evt_status <= 2'h0;
            evt_mask <= 2'h0;
            irq <= 1'b0;
        end else begin
            evt_status <= next_evt_status;
            evt_mask <= next_evt_mask;
            irq <= next_irq;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs, all from flops
    assign pready_o = pready;
    assign prdata_o = prdata;
    assign pslverr_o = pslverr;
    assign irq_req_o = pending_valid;
    assign irq_vector_o = pending_vector_number;
    assign irq_level_o = pending_new_level;
    assign alt_table_o = alternate_table_select;
    assign ext_edge_o = ext_edge;
    assign irq_o = irq;

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n);

    logic flag_wr;   // flag word written this cycle
    assign flag_wr = wr_en && apb_i.paddr == ipc_pkg::OFS_FLAG;

    property p_flag_sticky;
        request_flag[3] && !flag_wr |=> request_flag[3];
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) // RULE1
        else $error("flag dropped without a write");

    property p_enable_gate;
        (request_flag & source_enable) == 16'h0000 |=> !irq_req_o;
    endproperty
    a_enable_gate: assert property (p_enable_gate) // RULE2
        else $error("request without enabled flag");

    property p_vector_latch;
        best_found |=> irq_vector_o == ipc_pkg::VEC_BASE +
            {3'h0, $past(best_idx)} && irq_level_o == {1'b0, $past(best_prio)};
    endproperty
    a_vector_latch: assert property (p_vector_latch) // RULE4
        else $error("pending vector or level not latched");

    property p_nest_freeze;
        nesting_disable && !irq_ack_i |=> $stable(cpu_level_low);
    endproperty
    a_nest_freeze: assert property (p_nest_freeze) // RULE9
        else $error("level changed while nesting disabled");

    property p_trap_top;
        trap_any |=> cpu_level_top && prdata_o[31:16] == 16'h0000;
    endproperty
    a_trap_top: assert property (p_trap_top) // RULE7
        else $error("trap did not raise level top bit");

    property p_top_blocks;
        cpu_level_top |-> !best_found;
    endproperty
    a_top_blocks: assert property (p_top_blocks) // RULE8
        else $error("user irq allowed above level 7");

    property p_osc_flag;
        trap_i.osc |=> trap_flags[0] ##1 (trap_flags[0] || $past(wr_en));
    endproperty
    a_osc_flag: assert property (p_osc_flag) // RULE12
        else $error("oscillator trap flag not set");

    sequence s_ext0_rise;
        !ext_pin_i[0] ##1 ext_pin_i[0] && !edge_polarity[0];
    endsequence
    property p_ext0_rise;
        s_ext0_rise |=> request_flag[0] && ext_edge_o[0];
    endproperty
    a_ext0_rise: assert property (p_ext0_rise) // RULE15
        else $error("rising edge on pin 0 missed");

    property p_zero_hi;
        pready_o |-> prdata_o[31:16] == 16'h0000;
    endproperty
    a_zero_hi: assert property (p_zero_hi) // RULE16
        else $error("unimplemented bits read nonzero");

    property p_above_level;
        irq_req_o |-> {1'b0, irq_level_o[2:0]} >
            {$past(cpu_level_top), $past(cpu_level_low)};
    endproperty
    a_above_level: assert property (p_above_level) // RULE18
        else $error("request at or below cpu level");

endmodule : ipc_top

/* File: sim/ipc_cpu_model.sv */
`timescale 1ns/100ps
// cpu side: takes a pending request when the bench allows it
module ipc_cpu_model (
    input wire logic core_clk_i, // system clock
    input wire logic irq_req_i,  // pending request from block
    input wire logic ack_en_i,   // bench lets the cpu accept
    output logic irq_ack_o       // one-cycle take pulse
);
    // gap after each pulse, so one request is not taken twice in a row
    always_ff @(posedge core_clk_i) begin
        irq_ack_o <= ack_en_i & irq_req_i & ~irq_ack_o;
    end
endmodule : ipc_cpu_model

/* File: sim/testbench.sv */
`timescale 1ns/100ps
module testbench;
    logic core_clk_i = 0, reset_n_i = 0, hold = 0, ack_en = 0, ack;
    ipc_pkg::ipc_apb_req_t apb = '0;
    ipc_pkg::ipc_trap_t trap = '0;
    logic [15:0] src = '0;
    logic [4:0] pins = '0;
    logic pready, se, rse, irq_req, alt, irq;
    logic [31:0] prdata, rd;
    logic [6:0] vec;
    logic [3:0] lvl;
    int n_errors = 0, checked = 0;
    always #50 core_clk_i = ~core_clk_i;
    ipc_top ipc_top_i (.core_clk_i, .reset_n_i, .apb_i(apb),
        .pready_o(pready), .prdata_o(prdata), .pslverr_o(se),
        .src_req_i(src), .ext_pin_i(pins), .trap_i(trap),
        .irq_hold_i(hold), .irq_ack_i(ack), .irq_req_o(irq_req),
        .irq_vector_o(vec), .irq_level_o(lvl), .alt_table_o(alt),
        .ext_edge_o(), .irq_o(irq));
    ipc_cpu_model ipc_cpu_model_i (.core_clk_i, .irq_req_i(irq_req),
        .ack_en_i(ack_en), .irq_ack_o(ack));
    ////////////////////////////////////////////////////////////////////
    task chk(input string nm, input logic [31:0] got, exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s exp %h got %h", nm, exp, got);
        end
    endtask : chk
    task end_of_test;
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : end_of_test
    // apb cycle; idle edge after release keeps drives one per step
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        apb <= '{1'b1, 1'b0, w, a, d};
        @(posedge core_clk_i);
        apb.penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge core_clk_i);
            if (pready === 1'b1) break;
        end
        if (i == 20) begin
            n_errors++;
            end_of_test;
        end
        rd = prdata;
        rse = se;
        apb <= '0;
        @(posedge core_clk_i);
    endtask : xfer
    task rc(input string nm, input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, '0);
        chk(nm, rd, e);
    endtask : rc
    task cyc(input int n);
        repeat (n) @(posedge core_clk_i);
    endtask : cyc
    ////////////////////////////////////////////////////////////////////
    task t_reset;
        rc("ctrl1", ipc_pkg::OFS_CTRL_ONE, 0);
        rc("ctrl2", ipc_pkg::OFS_CTRL_TWO, 0);
        rc("core", ipc_pkg::OFS_CORE_CTRL, 0);
        rc("hole", 8'h3c, 0);
        chk("slverr", rse, 1);
    endtask : t_reset
    // source 3 outranks 2 but is disabled, so 2 must win
    task t_src;
        xfer(1, ipc_pkg::OFS_ENABLE, 32'h4);
        xfer(1, ipc_pkg::OFS_PRIO0, 32'h7500);
        src <= 16'h000c;
        cyc(1);
        src <= '0;
        cyc(3);
        chk("req", irq_req, 1);
        chk("vec", vec, 7'h0a);
        chk("lvl", lvl, 4'h5);
        rc("pend", ipc_pkg::OFS_PENDING, 32'h050a);
        xfer(1, ipc_pkg::OFS_CPU_STATUS, 32'ha0);
        cyc(1);
        chk("req_lvl", irq_req, 0);
        xfer(1, ipc_pkg::OFS_CPU_STATUS, 32'h80);
        cyc(1);
        chk("req_en", irq_req, 1);
        ack_en <= 1'b1;
        cyc(4);
        ack_en <= 1'b0;
        rc("lvl_ack", ipc_pkg::OFS_CPU_STATUS, 32'ha0);
        rc("flags", ipc_pkg::OFS_FLAG, 32'h0c);
        xfer(1, ipc_pkg::OFS_FLAG, 0);
        rc("flags0", ipc_pkg::OFS_FLAG, 0);
    endtask : t_src
    task t_nest;
        xfer(1, ipc_pkg::OFS_CTRL_ONE, '1);
        xfer(1, ipc_pkg::OFS_CPU_STATUS, 32'h40);
        rc("frozen", ipc_pkg::OFS_CPU_STATUS, 32'ha0);
        rc("ctrl1w", ipc_pkg::OFS_CTRL_ONE, 32'h807e);
        xfer(1, ipc_pkg::OFS_CTRL_ONE, 0);
    endtask : t_nest
    task t_trap;
        trap <= '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
        cyc(1);
        trap <= '0;
        cyc(2);
        rc("trapf", ipc_pkg::OFS_CTRL_ONE, 32'h52);
        rc("top", ipc_pkg::OFS_CORE_CTRL, 32'h8);
        xfer(1, ipc_pkg::OFS_EVT_MASK, 32'h2);
        chk("irq", irq, 1);
        xfer(1, ipc_pkg::OFS_EVT_STAT, 32'h2);
        chk("irq_clr", irq, 0);
        xfer(1, ipc_pkg::OFS_CORE_CTRL, 0);
        xfer(1, ipc_pkg::OFS_CORE_CTRL, 32'h8);
        rc("top0", ipc_pkg::OFS_CORE_CTRL, 0);
    endtask : t_trap
    task t_ctrl2;
        hold <= 1'b1;
        xfer(1, ipc_pkg::OFS_CTRL_TWO, 32'h8001);
        chk("alt", alt, 1);
        rc("ctrl2r", ipc_pkg::OFS_CTRL_TWO, 32'hc001);
        pins <= 5'h01;
        cyc(3);
        rc("rise", ipc_pkg::OFS_FLAG, 0);
        pins <= 5'h00;
        cyc(3);
        rc("fall", ipc_pkg::OFS_FLAG, 1);
        xfer(1, ipc_pkg::OFS_FLAG, 0);
        xfer(1, ipc_pkg::OFS_CTRL_TWO, 0);
        pins <= 5'h01;
        cyc(3);
        rc("rise0", ipc_pkg::OFS_FLAG, 1);
    endtask : t_ctrl2
    initial begin
        cyc(12);
        reset_n_i <= 1'b1;
        cyc(3);
        t_reset;
        t_src;
        t_nest;
        t_trap;
        t_ctrl2;
        end_of_test;
    end
endmodule : testbench
